// file: lsbc_defines.vh
// Constants for the LED sink blink control block.
// Assumes a 25 MHz aclk and 8-bit registers on 32-bit bus words.
`ifndef LSBC_DEFINES_VH
`define LSBC_DEFINES_VH

// Register indices and byte addresses (index times four)
`define LSBC_IDX_FADE     8'h0f
`define LSBC_IDX_ENABLE   8'h10
`define LSBC_IDX_TIME1    8'h11
`define LSBC_IDX_STATUS   8'h20
`define LSBC_ADDR_FADE    (`LSBC_IDX_FADE << 2)
`define LSBC_ADDR_ENABLE  (`LSBC_IDX_ENABLE << 2)
`define LSBC_ADDR_TIME1   (`LSBC_IDX_TIME1 << 2)
`define LSBC_ADDR_STATUS  (`LSBC_IDX_STATUS << 2)

// Reset values
`define LSBC_RST_FADE     2'h0
`define LSBC_RST_ENABLE   7'h00
`define LSBC_RST_TIME1    8'h00

// Field positions
`define LSBC_LAW_MSB      1
`define LSBC_LAW_LSB      0
`define LSBC_EN_MSB       6
`define LSBC_ON_MSB       7
`define LSBC_ON_LSB       6
`define LSBC_OFF7_MSB     5
`define LSBC_OFF7_LSB     4
`define LSBC_OFF6_MSB     3
`define LSBC_OFF6_LSB     2
`define LSBC_OFF5_MSB     1
`define LSBC_OFF5_LSB     0

// Fade law codes
`define LSBC_LAW_LINEAR   2'h0
`define LSBC_LAW_SQUARE   2'h1
`define LSBC_LAW_CUBIC10  2'h2
`define LSBC_LAW_CUBIC11  2'h3

// Timebase: one tick is 0.1 s
`define LSBC_CLK_NS       40
`define LSBC_TICK_NS      100000000
`define LSBC_TICK_CYCLES  (`LSBC_TICK_NS / `LSBC_CLK_NS)

// On durations in ticks of 0.1 s
`define LSBC_ON_T00       5'd2
`define LSBC_ON_T01       5'd6
`define LSBC_ON_T10       5'd8
`define LSBC_ON_T11       5'd12

// Off durations in ticks of 0.1 s, zero means no off phase
`define LSBC_OFF_T00      5'd0
`define LSBC_OFF_T01      5'd6
`define LSBC_OFF_T10      5'd12
`define LSBC_OFF_T11      5'd18

// AXI responses
`define LSBC_RESP_OKAY    2'h0
`define LSBC_RESP_SLVERR  2'h2

`endif

// file: lsbc_sink_timer.v
// Per-sink on/off phase timer for the blink sequence.
// Assumes tick is a one-cycle pulse from the shared 0.1 s timebase.
`timescale 1ns/1ps

module lsbc_sink_timer (
  // Clock and reset
  input  wire       aclk,
  input  wire       aresetn,
  // Control
  input  wire       enable,
  input  wire       start,
  input  wire       tick,
  input  wire [4:0] on_ticks,
  input  wire [4:0] off_ticks,
  // Output
  output reg        sink_on
);

  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_ON   = 2'd1;
  localparam [1:0] ST_OFF  = 2'd2;

  reg  [1:0] state;
  reg  [4:0] cnt;
  wire [4:0] cnt_inc;

  assign cnt_inc = cnt + 5'd1;

  always @(posedge aclk) begin
    if (!aresetn) begin
      state   <= ST_IDLE;
      cnt     <= 5'd0;
      sink_on <= 1'b0;
    end else if (!enable) begin
      state   <= ST_IDLE;
      cnt     <= 5'd0;
      sink_on <= 1'b0;
    end else if (start) begin
      state   <= ST_ON;
      cnt     <= 5'd0;
      sink_on <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          state   <= ST_ON;
          cnt     <= 5'd0;
          sink_on <= 1'b1;
        end
        ST_ON: begin
          if (off_ticks == 5'd0) begin
            cnt     <= 5'd0;
            sink_on <= 1'b1;
          end else if (tick) begin
            if (cnt_inc >= on_ticks) begin
              state   <= ST_OFF;
              cnt     <= 5'd0;
              sink_on <= 1'b0;
            end else begin
              cnt <= cnt_inc;
            end
          end
        end
        ST_OFF: begin
          if (off_ticks == 5'd0) begin
            state   <= ST_ON;
            cnt     <= 5'd0;
            sink_on <= 1'b1;
          end else if (tick) begin
            if (cnt_inc >= off_ticks) begin
              state   <= ST_ON;
              cnt     <= 5'd0;
              sink_on <= 1'b1;
            end else begin
              cnt <= cnt_inc;
            end
          end
        end
        default: begin
          state   <= ST_IDLE;
          cnt     <= 5'd0;
          sink_on <= 1'b0;
        end
      endcase
    end
  end

endmodule

// file: lsbc_top.v
// LED sink blink control: fade law, sink enables, blink timing.
// Assumes an AXI4-Lite master on aclk; low sink off codes come from
// another block on the same clock.
`timescale 1ns/1ps

`include "lsbc_defines.vh"

module lsbc_top #(
  parameter NUM_SINKS   = 7,
  parameter TICK_W      = 22,
  parameter TICK_CYCLES = `LSBC_TICK_CYCLES
) (
  // Clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // AXI4-Lite write address
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  // AXI4-Lite write data
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // AXI4-Lite read address
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  // AXI4-Lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // Off codes of sinks 4..1, two bits each
  input  wire [7:0]  low_sink_off_time,
  // Fade law controls
  output reg  [1:0]  fade_law_select,
  output reg         dac_square_law,
  output reg         nonlinear_time_steps,
  output reg         cubic_profile_11,
  // Sink drive
  output wire [6:0]  sink_on
);

  // Register state
  reg  [6:0]  sink_n_enable;
  reg  [7:0]  time_upper;
  reg  [6:0]  enable_prev;

  // Write channel state
  reg         aw_held;
  reg         w_held;
  reg  [7:0]  aw_addr;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  // Timebase
  reg  [TICK_W-1:0] tick_cnt;
  reg               tick;

  wire        aw_fire;
  wire        w_fire;
  wire        ar_fire;
  wire        wr_go;
  wire [7:0]  wr_addr;
  wire [31:0] wr_data;
  wire [3:0]  wr_strb;
  wire        wr_low;
  wire [6:0]  start;
  wire        any_start;
  wire [1:0]  shared_on_time;
  wire [4:0]  on_ticks;
  wire [13:0] off_codes;
  // Status word mirrors the live sink drive

  // Decode shared on code to ticks of 0.1 s
  function [4:0] on_decode;
    input [1:0] code;
    begin
      case (code)
        2'h0:    on_decode = `LSBC_ON_T00;
        2'h1:    on_decode = `LSBC_ON_T01;
        2'h2:    on_decode = `LSBC_ON_T10;
        default: on_decode = `LSBC_ON_T11;
      endcase
    end
  endfunction

  // Decode an off code to ticks, zero when off phase disabled
  function [4:0] off_decode;
    input [1:0] code;
    begin
      case (code)
        2'h0:    off_decode = `LSBC_OFF_T00;
        2'h1:    off_decode = `LSBC_OFF_T01;
        2'h2:    off_decode = `LSBC_OFF_T10;
        default: off_decode = `LSBC_OFF_T11;
      endcase
    end
  endfunction

  // Address match against a register byte address
  function addr_is;
    input [7:0] addr;
    input [7:0] reg_addr;
    begin
      addr_is = (addr[7:2] == reg_addr[7:2]);
    end
  endfunction

  // Mapped register test
  function addr_mapped;
    input [7:0] addr;
    begin
      addr_mapped = addr_is(addr, `LSBC_ADDR_FADE) ||
                    addr_is(addr, `LSBC_ADDR_ENABLE) ||
                    addr_is(addr, `LSBC_ADDR_TIME1) ||
                    addr_is(addr, `LSBC_ADDR_STATUS);
    end
  endfunction

  // Write address and data taken independently
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign aw_fire       = s_axi_awvalid && s_axi_awready;
  assign w_fire        = s_axi_wvalid && s_axi_wready;

  // Write proceeds once both halves are present
  assign wr_go   = (aw_held || aw_fire) && (w_held || w_fire);
  assign wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data = w_held ? w_data : s_axi_wdata;
  assign wr_strb = w_held ? w_strb : s_axi_wstrb;
  assign wr_low  = wr_go && wr_strb[0];

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else if (wr_go) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
    end else begin
      if (aw_fire) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
    end
  end

  // Write response
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `LSBC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= addr_mapped(wr_addr) ? `LSBC_RESP_OKAY
                                           : `LSBC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; reserved bits are not stored
  always @(posedge aclk) begin
    if (!aresetn) begin
      fade_law_select <= `LSBC_RST_FADE;
      sink_n_enable   <= `LSBC_RST_ENABLE;
      time_upper      <= `LSBC_RST_TIME1;
    end else if (wr_low) begin
      if (addr_is(wr_addr, `LSBC_ADDR_FADE)) begin
        fade_law_select <= wr_data[`LSBC_LAW_MSB:`LSBC_LAW_LSB];
      end
      if (addr_is(wr_addr, `LSBC_ADDR_ENABLE)) begin
        sink_n_enable <= wr_data[`LSBC_EN_MSB:0];
      end
      if (addr_is(wr_addr, `LSBC_ADDR_TIME1)) begin
        time_upper <= wr_data[7:0];
      end
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `LSBC_RESP_OKAY;
    end else if (ar_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `LSBC_RESP_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
      if (addr_is(s_axi_araddr, `LSBC_ADDR_FADE)) begin
        s_axi_rdata[1:0] <= fade_law_select;
      end else if (addr_is(s_axi_araddr, `LSBC_ADDR_ENABLE)) begin
        s_axi_rdata[6:0] <= sink_n_enable;
      end else if (addr_is(s_axi_araddr, `LSBC_ADDR_TIME1)) begin
        s_axi_rdata[7:0] <= time_upper;
      end else if (addr_is(s_axi_araddr, `LSBC_ADDR_STATUS)) begin
        s_axi_rdata[6:0] <= sink_on;
      end else begin
        s_axi_rresp <= `LSBC_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Fade law decode for the DAC and fade engine
  always @(posedge aclk) begin
    if (!aresetn) begin
      dac_square_law       <= 1'b0;
      nonlinear_time_steps <= 1'b0;
      cubic_profile_11     <= 1'b0;
    end else begin
      case (fade_law_select)
        `LSBC_LAW_LINEAR: begin
          dac_square_law       <= 1'b0;
          nonlinear_time_steps <= 1'b0;
          cubic_profile_11     <= 1'b0;
        end
        `LSBC_LAW_SQUARE: begin
          dac_square_law       <= 1'b1;
          nonlinear_time_steps <= 1'b0;
          cubic_profile_11     <= 1'b0;
        end
        `LSBC_LAW_CUBIC10: begin
          dac_square_law       <= 1'b1;
          nonlinear_time_steps <= 1'b1;
          cubic_profile_11     <= 1'b0;
        end
        default: begin
          dac_square_law       <= 1'b1;
          nonlinear_time_steps <= 1'b1;
          cubic_profile_11     <= 1'b1;
        end
      endcase
    end
  end

  // Enable rise detection; one write raises all its bits together
  always @(posedge aclk) begin
    if (!aresetn) begin
      enable_prev <= 7'h00;
    end else begin
      enable_prev <= sink_n_enable;
    end
  end

  assign start     = sink_n_enable & ~enable_prev;
  assign any_start = |start;

  // Shared 0.1 s timebase, restarted when any sink starts so that
  // sinks started together see identical tick timing
  always @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt <= {TICK_W{1'b0}};
      tick     <= 1'b0;
    end else if (any_start) begin
      tick_cnt <= {TICK_W{1'b0}};
      tick     <= 1'b0;
    end else if (tick_cnt == TICK_CYCLES[TICK_W-1:0] - 1'b1) begin
      tick_cnt <= {TICK_W{1'b0}};
      tick     <= 1'b1;
    end else begin
      tick_cnt <= tick_cnt + 1'b1;
      tick     <= 1'b0;
    end
  end

  // Timing fields
  assign shared_on_time = time_upper[`LSBC_ON_MSB:`LSBC_ON_LSB];
  assign on_ticks       = on_decode(shared_on_time);

  // Off codes, sink 7 in the top pair down to sink 1 at the bottom
  assign off_codes = {time_upper[`LSBC_OFF7_MSB:`LSBC_OFF7_LSB],
                      time_upper[`LSBC_OFF6_MSB:`LSBC_OFF6_LSB],
                      time_upper[`LSBC_OFF5_MSB:`LSBC_OFF5_LSB],
                      low_sink_off_time};

  // Per-sink timers
  genvar i;
  generate
    for (i = 0; i < NUM_SINKS; i = i + 1) begin : g_sink
      wire [4:0] off_ticks;

      assign off_ticks = off_decode(off_codes[2*i+1:2*i]);
      // Code changes act at once on the running phase count

      lsbc_sink_timer u_timer (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .enable    (sink_n_enable[i]),
        .start     (start[i]),
        .tick      (tick),
        .on_ticks  (on_ticks),
        .off_ticks (off_ticks),
        .sink_on   (sink_on[i])
      );
    end
  endgenerate

endmodule

// file: lsbc_monitor.sv
// Checker for the LED sink blink control block.
// Bound to lsbc_top below; sees only the top's ports, tick of TICK_CYCLES.
`timescale 1ns/1ps
module lsbc_monitor #(
  parameter TICK_CYCLES = 4
) (
  // Clock and reset
  input wire        aclk,
  input wire        aresetn,
  // Write address and data
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire [7:0]  s_axi_awaddr,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0]  s_axi_wstrb,
  // Sink and law side
  input wire [7:0]  low_sink_off_time,
  input wire [1:0]  fade_law_select,
  input wire        dac_square_law,
  input wire        nonlinear_time_steps,
  input wire        cubic_profile_11,
  input wire [6:0]  sink_on
);
  reg  [6:0]  en_sh;
  reg  [7:0]  t1_sh;
  reg  [13:0] prev_codes;
  reg  [6:0]  rise_m;
  reg  [7:0]  on_cnt;
  reg  [6:0]  steady;
  integer     k;
  wire        wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                   s_axi_wready && s_axi_wstrb[0];
  wire        wr_en = wr && s_axi_awaddr == 8'h40;
  wire [13:0] codes = {t1_sh[5:0], low_sink_off_time};
  wire [31:0] on_exp = TICK_CYCLES * (t1_sh[7:6] == 2'h0 ? 2 :
                       t1_sh[7:6] == 2'h1 ? 6 : t1_sh[7:6] == 2'h2 ? 8 : 12);

  // Enabled sinks whose off code is zero now and a cycle ago
  always @* begin
    for (k = 0; k < 7; k = k + 1)
      steady[k] = en_sh[k] && codes[2*k +: 2] == 2'h0 &&
                  prev_codes[2*k +: 2] == 2'h0;
  end

  // Shadows of the enable and timing registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      en_sh      <= 7'h00;
      t1_sh      <= 8'h00;
      prev_codes <= 14'h0000;
      rise_m     <= 7'h00;
      on_cnt     <= 8'h00;
    end else begin
      if (wr_en)
        en_sh <= s_axi_wdata[6:0];
      if (wr && s_axi_awaddr == 8'h44)
        t1_sh <= s_axi_wdata[7:0];
      prev_codes <= codes;
      rise_m     <= wr_en ? s_axi_wdata[6:0] & ~en_sh : 7'h00;
      on_cnt     <= sink_on[4] ? on_cnt + 8'h01 : 8'h00;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_sq;
    $stable(fade_law_select) |-> dac_square_law == (fade_law_select != 2'h0);
  endproperty
  a_sq: assert property (p_sq) else $error("square flag wrong");
  property p_nl;
    $stable(fade_law_select) |-> nonlinear_time_steps == fade_law_select[1];
  endproperty
  a_nl: assert property (p_nl) else $error("step flag wrong");
  property p_c11;
    $stable(fade_law_select) |-> cubic_profile_11 == (fade_law_select == 2'h3);
  endproperty
  a_c11: assert property (p_c11) else $error("cubic flag wrong");
  property p_law_wr;
    wr && s_axi_awaddr == 8'h3c |->
      ##2 fade_law_select == $past(s_axi_wdata[1:0], 2);
  endproperty
  a_law_wr: assert property (p_law_wr) else $error("law not stored");
  property p_en_clr;
    wr_en |-> ##3 (sink_on & ~$past(s_axi_wdata[6:0], 3)) == 7'h00;
  endproperty
  a_en_clr: assert property (p_en_clr) else $error("sink not off");
  property p_en_rise;
    rise_m != 7'h00 |-> ##2 (sink_on & $past(rise_m, 2)) == $past(rise_m, 2);
  endproperty
  a_en_rise: assert property (p_en_rise) else $error("no on phase");
  property p_no_fall;
    (steady & $past(sink_on) & ~sink_on) == 7'h00;
  endproperty
  a_no_fall: assert property (p_no_fall) else $error("steady fell");
  property p_on;
    (steady & $past(steady) & $past(steady, 2) & ~sink_on) == 7'h00;
  endproperty
  a_on: assert property (p_on) else $error("steady sink off");
  property p_on_len;
    $fell(sink_on[4]) && en_sh[4] && t1_sh[1:0] != 2'h0 |->
      on_cnt + 1 >= on_exp && on_cnt <= on_exp + TICK_CYCLES + 1;
  endproperty
  a_on_len: assert property (p_on_len) else $error("on time");
endmodule

bind lsbc_top lsbc_monitor #(.TICK_CYCLES(TICK_CYCLES)) u_mon (
  .aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_awaddr(s_axi_awaddr),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .low_sink_off_time(low_sink_off_time),
  .fade_law_select(fade_law_select), .dac_square_law(dac_square_law),
  .nonlinear_time_steps(nonlinear_time_steps),
  .cubic_profile_11(cubic_profile_11), .sink_on(sink_on)
);

// file: test_led_sink_blink_control.sv
// Bench for the LED sink blink control block over AXI4-Lite.
// Assumes lsbc_top with a 4-cycle tick; the checker is bound to it.
`timescale 1ns/1ps
`include "lsbc_defines.vh"
module test_led_sink_blink_control;
  localparam int T = 4;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, low_sink_off_time;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, rd, r;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  rs, on, off;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire         s_axi_rvalid, dac_square_law, nonlinear_time_steps;
  wire         cubic_profile_11;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, fade_law_select;
  wire  [31:0] s_axi_rdata;
  wire  [6:0]  sink_on;
  int          n_mismatch, samples_checked, cyc, lo, hi, k, n;

  lsbc_top #(.TICK_CYCLES(T)) DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(s_axi_awprot),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(s_axi_arprot),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .low_sink_off_time(low_sink_off_time),
    .fade_law_select(fade_law_select), .dac_square_law(dac_square_law),
    .nonlinear_time_steps(nonlinear_time_steps),
    .cubic_profile_11(cubic_profile_11), .sink_on(sink_on)
  );

  initial begin
    aclk = 1'h0;
    forever #20 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, e, input string m);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask

  function automatic int on_c(input logic [1:0] x);
    return T * (x == 2'h0 ? 2 : x == 2'h1 ? 6 : x == 2'h2 ? 8 : 12);
  endfunction

  // Address and data offered together, each released when taken
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    tb = 1'h0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    repeat (50) if (!tb) begin
      @(negedge aclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) s_axi_bready <= 1'h0;
    end
    if (!tb) chk(0, 1, "no write response");
  endtask

  task automatic rd_reg(input logic [7:0] a);
    logic ta, tr;
    tr = 1'h0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    repeat (50) if (!tr) begin
      @(negedge aclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) s_axi_rready <= 1'h0;
    end
    if (!tr) chk(0, 1, "no read data");
  endtask

  initial begin
    aresetn = 1'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    low_sink_off_time = 8'h00;
    n = $urandom(75);
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    for (k = 0; k < 3; k++) begin
      rd_reg(8'h3c + 8'(4 * k));
      chk({rs, rd[29:0]}, {`LSBC_RESP_OKAY, 30'h0}, "reset value");
    end
    wr_reg(8'h08, 32'hff);
    chk(rs, `LSBC_RESP_SLVERR, "unmapped write");
    rd_reg(8'h08);
    chk({rs, rd[29:0]}, {`LSBC_RESP_SLVERR, 30'h0}, "unmapped read");
    wr_reg(`LSBC_ADDR_STATUS, 32'h7f);
    chk(rs, `LSBC_RESP_OKAY, "status write");
    s_axi_wstrb <= 4'h0;
    wr_reg(`LSBC_ADDR_FADE, 32'h3);
    s_axi_wstrb <= 4'hf;
    rd_reg(`LSBC_ADDR_FADE);
    chk(rd, 0, "masked write");
    for (k = 0; k < 4; k++) begin
      wr_reg(`LSBC_ADDR_FADE, ($urandom & 32'hfc) | k);
      rd_reg(`LSBC_ADDR_FADE);
      chk(rd, k, "law readback");
      @(negedge aclk);
      chk({fade_law_select, dac_square_law, nonlinear_time_steps,
           cubic_profile_11}, {k[1:0], k != 0, k[1], k == 3}, "law");
    end
    wr_reg(`LSBC_ADDR_TIME1, $urandom & 32'hc0);
    for (k = 0; k < 5; k++) begin
      r = k == 0 ? 32'hff : k == 1 ? 32'h0 : $urandom;
      wr_reg(`LSBC_ADDR_ENABLE, r);
      rd_reg(`LSBC_ADDR_ENABLE);
      chk(rd, r & 32'h7f, "enable readback");
      repeat (30) @(negedge aclk);
      chk(sink_on, r & 32'h7f, "steady sinks");
    end
    // All sinks share codes and start in one write
    for (int c = 0; c < 12; c++) begin
      on = c[1:0];
      off = 2'(c / 4 + 1);
      k = c % 7;
      wr_reg(`LSBC_ADDR_ENABLE, 32'h0);
      low_sink_off_time <= {4{off}};
      wr_reg(`LSBC_ADDR_TIME1, {24'h0, on, off, off, off});
      wr_reg(`LSBC_ADDR_ENABLE, 32'h7f);
      {n, lo, hi, r} = 0;
      @(negedge aclk);
      while (!sink_on[k] && n < 9) begin
        n++;
        @(negedge aclk);
      end
      chk(n < 4, 1, "late start");
      while (sink_on[k] && lo < 99) begin
        lo++;
        r |= sink_on ^ 7'h7f;
        @(negedge aclk);
      end
      while (!sink_on[k] && hi < 99) begin
        hi++;
        r |= sink_on;
        @(negedge aclk);
      end
      chk(r, 0, "out of step");
      chk(lo >= on_c(on) - 1 && lo <= on_c(on) + T, 1, "on");
      chk(hi >= 6 * off * T - 1 && hi <= 6 * off * T + T, 1, "off");
    end
    low_sink_off_time <= 8'h00;
    for (k = 4; k < 7; k++) begin
      wr_reg(`LSBC_ADDR_ENABLE, 32'h0);
      wr_reg(`LSBC_ADDR_TIME1, 32'h1 << (2 * k - 8));
      wr_reg(`LSBC_ADDR_ENABLE, 32'hff);
      repeat (20) @(negedge aclk);
      chk(sink_on, 32'h7f ^ (1 << k), "field position");
      rd_reg(`LSBC_ADDR_STATUS);
      chk(rd, 32'h7f ^ (1 << k), "status word");
    end
    wr_reg(`LSBC_ADDR_ENABLE, 32'h0);
    repeat (2) @(negedge aclk);
    chk(sink_on, 0, "cleared sinks");
    wr_reg(`LSBC_ADDR_ENABLE, 32'h55);
    @(posedge aclk);
    aresetn <= 1'h0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    rd_reg(`LSBC_ADDR_ENABLE);
    chk(rd, 0, "enable after reset");
    chk(sink_on, 0, "sinks after reset");
    wrap_up();
  end
endmodule
